// file: wrm_pkg.sv
// package: constants and types shared by the reset/supply monitor ends
package wrm_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned SETTLE_TIME_NS    = 1000;
	localparam int unsigned SETTLE_CYCLES     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_PULSE_CYC   = 4;
	// ----------------------------------------------------------------
	// reset vector layout
	// ----------------------------------------------------------------
	localparam int unsigned VEC_W             = 32;
	localparam int unsigned BUS_SEL_LSB       = 0;
	localparam int unsigned BUS_SEL_W         = 2;
	localparam logic [1:0]  BUS_SEL_SINGLE    = 2'h0;
	// ----------------------------------------------------------------
	// register map of the controller's software port (word indices)
	// ----------------------------------------------------------------
	localparam logic [3:0]  ADR_CTRL          = 4'h0;
	localparam logic [3:0]  ADR_STATUS        = 4'h1;
	localparam logic [3:0]  ADR_LEVEL         = 4'h2;
	localparam logic [3:0]  ADR_VECTOR        = 4'h3;
	localparam logic [3:0]  ADR_MODE          = 4'h4;
	// ctrl bits
	localparam int unsigned CTRL_EN_BIT       = 0;
	localparam int unsigned CTRL_IEN_BIT      = 1;
	localparam int unsigned CTRL_UNLOCK_BIT   = 2;
	localparam int unsigned CTRL_WDT_RST_BIT  = 3;
	// status bits
	localparam int unsigned ST_LEVEL_BIT      = 0;
	localparam int unsigned ST_CROSS_BIT      = 1;
	localparam int unsigned ST_VALID_BIT      = 2;
	localparam int unsigned ST_SHARED_IRQ_BIT = 3;
	// reset values
	localparam logic [3:0]  LEVEL_RST         = 4'h0;
	localparam logic [1:0]  MODE_RST          = 2'h0;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WRM_OFF    = 2'b00,
		WRM_SETTLE = 2'b01,
		WRM_WATCH  = 2'b10
	} wrm_det_state_t;
endpackage

// file: wrm_if.sv
// interface: link between the reset/monitor device and its cpu-side controller
`timescale 1ns/1ps
interface wrm_if;
	logic        detector_enable;
	logic        supply_irq_enable;
	logic        monitor_write_unlock;
	logic        wdt_reset_select;
	logic [3:0]  detect_level_select;
	logic        level_wr;
	logic        crossing_clr;
	logic [31:0] reset_vector;
	logic [1:0]  processor_mode_wr;
	logic        mode_wr;
	logic        supply_level_flag;
	logic        supply_crossing_flag;
	logic        det_valid;
	logic        shared_irq;
	logic        sys_reset;
	logic [31:0] start_addr;
	logic [1:0]  bus_width_sel;
	logic [1:0]  processor_mode;
	logic [3:0]  level_cur;

	modport dev (
		input  detector_enable, supply_irq_enable, monitor_write_unlock, wdt_reset_select,
		input  detect_level_select, level_wr, crossing_clr, reset_vector,
		input  processor_mode_wr, mode_wr,
		output supply_level_flag, supply_crossing_flag, det_valid, shared_irq,
		output sys_reset, start_addr, bus_width_sel, processor_mode, level_cur
	);
	modport ctl (
		output detector_enable, supply_irq_enable, monitor_write_unlock, wdt_reset_select,
		output detect_level_select, level_wr, crossing_clr, reset_vector,
		output processor_mode_wr, mode_wr,
		input  supply_level_flag, supply_crossing_flag, det_valid, shared_irq,
		input  sys_reset, start_addr, bus_width_sel, processor_mode, level_cur
	);
endinterface

// file: wrm_device.sv
// device end: watchdog reset, reset vector decode and supply detector logic
//
// Functional notes
// RL1 - watchdog underflow with select resets, vectors restart
// RL2 - watchdog reset keeps processor mode bits
// RL3 - start address is vector upper 30 bits
// RL4 - vector low 2 bits select bus width
// RL5 - supplier aligns vector, 00b for single-chip
// RL6 - comparator ignored until settle time elapsed
// RL7 - falling crossing clears level, sets sticky flag
// RL8 - rising crossing sets level and sticky flag
// RL9 - request on sticky rise when enabled
// RL10 - sticky flag cleared only by software; the code also clears it on the watchdog reset
// RL11 - request shared with watchdog, oscillator stop
// RL12 - software unlocks, disables before level rewrite
// RL13 - comparators synchronised; set beats clear
// RL14 - level write ignored unless unlocked, disabled
`timescale 1ns/1ps
module wrm_device
	import wrm_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	// analog comparator outputs (asynchronous)
	input  wire logic i_cmp_below_fall,
	input  wire logic i_cmp_above_rise,
	// other reset and interrupt sources
	input  wire logic i_wdt_underflow,
	input  wire logic i_wdt_irq,
	input  wire logic i_osc_stop_irq,
	// controller side
	wrm_if.dev        bus
);
	// a zero wait would skip the settle state and trust the first comparator sample
	if (SETTLE_CYC < 1) begin
		$error("SETTLE_CYC must be at least 1");
	end

	localparam int CNT_W = $clog2(SETTLE_CYC + 1);

	// ----------------------------------------------------------------
	// comparator synchronisers
	// ----------------------------------------------------------------
	logic [1:0] fall_sync_r;
	logic [1:0] rise_sync_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fall_sync_r <= 2'h0;
			rise_sync_r <= 2'h0;
		end else begin
			fall_sync_r <= {fall_sync_r[0], i_cmp_below_fall}; // [RL13]
			rise_sync_r <= {rise_sync_r[0], i_cmp_above_rise}; // [RL13]
		end
	end
	logic below_s;
	logic above_s;
	assign below_s = fall_sync_r[1];
	assign above_s = rise_sync_r[1];

	// ----------------------------------------------------------------
	// watchdog reset pulse and mode bits
	// ----------------------------------------------------------------
	logic [2:0] rst_cnt_r;
	logic       sys_reset_r;
	logic       wdt_fire;
	assign wdt_fire = i_wdt_underflow && bus.wdt_reset_select && !sys_reset_r; // [RL1]
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rst_cnt_r   <= 3'h0;
			sys_reset_r <= 1'b0;
		end else if (wdt_fire) begin
			rst_cnt_r   <= 3'(RESET_PULSE_CYC - 1);
			sys_reset_r <= 1'b1; // [RL1]
		end else if (rst_cnt_r != 3'h0) begin
			rst_cnt_r <= rst_cnt_r - 3'h1;
		end else begin
			sys_reset_r <= 1'b0;
		end
	end
	assign bus.sys_reset = sys_reset_r;

	// mode bits survive the watchdog reset; only i_rst clears them
	logic [1:0] mode_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_r <= MODE_RST;
		end else if (bus.mode_wr && !sys_reset_r) begin
			mode_r <= bus.processor_mode_wr; // [RL2]
		end
	end
	assign bus.processor_mode = mode_r;

	// ----------------------------------------------------------------
	// reset vector decode
	// ----------------------------------------------------------------
	logic [31:0] start_r;
	logic [1:0]  bw_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			start_r <= 32'h0;
			bw_r    <= 2'h0;
		end else begin
			start_r <= {bus.reset_vector[31:2], 2'b00}; // [RL3] [RL5]
			bw_r    <= bus.reset_vector[BUS_SEL_LSB +: BUS_SEL_W]; // [RL4]
		end
	end
	assign bus.start_addr    = start_r;
	assign bus.bus_width_sel = bw_r;

	// ----------------------------------------------------------------
	// detection level register
	// ----------------------------------------------------------------
	logic [3:0] level_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || sys_reset_r) begin
			level_r <= LEVEL_RST; // [RL1]
		end else if (bus.level_wr && bus.monitor_write_unlock && !bus.detector_enable) begin
			level_r <= bus.detect_level_select; // [RL14] [RL12]
		end
	end
	assign bus.level_cur = level_r;

	// ----------------------------------------------------------------
	// detector enable and settle wait
	// ----------------------------------------------------------------
	wrm_det_state_t    st_r;
	logic [CNT_W-1:0]  cnt_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || sys_reset_r) begin
			st_r  <= WRM_OFF;
			cnt_r <= '0;
		end else begin
			case (st_r)
				WRM_OFF: begin
					if (bus.detector_enable) begin
						st_r  <= WRM_SETTLE;
						cnt_r <= CNT_W'(SETTLE_CYC - 1);
					end
				end
				WRM_SETTLE: begin
					if (!bus.detector_enable) begin
						st_r <= WRM_OFF;
					end else if (cnt_r == '0) begin
						st_r <= WRM_WATCH; // [RL6]
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				WRM_WATCH: begin
					if (!bus.detector_enable) begin
						st_r <= WRM_OFF;
					end
				end
				default: st_r <= WRM_OFF;
			endcase
		end
	end
	logic valid;
	assign valid         = (st_r == WRM_WATCH);
	assign bus.det_valid = valid;

	// ----------------------------------------------------------------
	// level and sticky crossing flags
	// ----------------------------------------------------------------
	logic lvl_flag_r;
	logic cross_r;
	logic fall_evt;
	logic rise_evt;
	// crossings are edges of the level flag; level seeds on entering watch
	logic armed_r;
	assign fall_evt = valid && armed_r && lvl_flag_r && below_s; // [RL6]
	assign rise_evt = valid && armed_r && !lvl_flag_r && above_s && !below_s; // [RL6]
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || sys_reset_r) begin
			lvl_flag_r <= 1'b1;
			armed_r    <= 1'b0;
		end else if (!valid) begin
			armed_r <= 1'b0;
		end else if (!armed_r) begin
			lvl_flag_r <= !below_s;
			armed_r    <= 1'b1;
		end else if (fall_evt) begin
			lvl_flag_r <= 1'b0; // [RL7]
		end else if (rise_evt) begin
			lvl_flag_r <= 1'b1; // [RL8]
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || sys_reset_r) begin
			cross_r <= 1'b0;
		end else if (fall_evt || rise_evt) begin
			cross_r <= 1'b1; // [RL7] [RL8] [RL13]
		end else if (bus.crossing_clr) begin
			cross_r <= 1'b0; // [RL10]
		end
	end
	assign bus.supply_level_flag    = lvl_flag_r;
	assign bus.supply_crossing_flag = cross_r;

	// ----------------------------------------------------------------
	// interrupt request
	// ----------------------------------------------------------------
	logic irq_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || sys_reset_r) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (!cross_r && (fall_evt || rise_evt) && bus.supply_irq_enable) // [RL9]
			         || i_wdt_irq || i_osc_stop_irq; // [RL11]
		end
	end
	assign bus.shared_irq = irq_r;
endmodule

// file: wrm_ctrl.sv
// controller end: software register port driving the device link
`timescale 1ns/1ps
module wrm_ctrl
	import wrm_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// software port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// interrupt to the cpu (shared vector)
	output logic             o_irq,
	// device side
	wrm_if.ctl               bus
);
	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [3:0]  ctrl_r;
	logic [31:0] vec_r;
	// control bits are cleared by the watchdog reset too; a write during it is lost
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || bus.sys_reset) begin
			ctrl_r <= 4'h0; // [RL1]
		end else if (i_wr && i_addr == ADR_CTRL) begin
			ctrl_r <= i_wdata[3:0];
		end
	end
	// the vector is boot content, not a control register, so it survives
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			vec_r <= 32'h0;
		end else if (i_wr && i_addr == ADR_VECTOR) begin
			vec_r <= i_wdata;
		end
	end
	assign bus.detector_enable      = ctrl_r[CTRL_EN_BIT];
	assign bus.supply_irq_enable    = ctrl_r[CTRL_IEN_BIT];
	assign bus.monitor_write_unlock = ctrl_r[CTRL_UNLOCK_BIT]; // [RL12]
	assign bus.wdt_reset_select     = ctrl_r[CTRL_WDT_RST_BIT];
	assign bus.reset_vector         = vec_r; // [RL5]

	// one-cycle strobes straight from the port
	assign bus.level_wr            = i_wr && i_addr == ADR_LEVEL;
	assign bus.detect_level_select = i_wdata[3:0];
	assign bus.mode_wr             = i_wr && i_addr == ADR_MODE;
	assign bus.processor_mode_wr   = i_wdata[1:0];
	// writing 0 to the crossing bit clears it
	assign bus.crossing_clr = i_wr && i_addr == ADR_STATUS && !i_wdata[ST_CROSS_BIT]; // [RL10]
	assign o_irq = bus.shared_irq; // [RL11]

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			case (i_addr)
				ADR_CTRL:   o_rdata <= {28'h0, ctrl_r};
				ADR_STATUS: o_rdata <= {28'h0, bus.shared_irq, bus.det_valid,
				                        bus.supply_crossing_flag, bus.supply_level_flag};
				ADR_LEVEL:  o_rdata <= {28'h0, bus.level_cur};
				ADR_VECTOR: o_rdata <= bus.start_addr;
				ADR_MODE:   o_rdata <= {28'h0, bus.bus_width_sel, bus.processor_mode};
				default:    o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end
endmodule

// file: wrm_mon_properties.sv
// checker: timing relations watched on the reset/monitor link
`timescale 1ns/1ps
module wrm_props (
	// clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	// link signals
	input wire logic        detector_enable,
	input wire logic        monitor_write_unlock,
	input wire logic        supply_irq_enable,
	input wire logic [3:0]  detect_level_select,
	input wire logic        level_wr,
	input wire logic        crossing_clr,
	input wire logic [31:0] reset_vector,
	input wire logic        supply_level_flag,
	input wire logic        supply_crossing_flag,
	input wire logic        det_valid,
	input wire logic        shared_irq,
	input wire logic        sys_reset,
	input wire logic [31:0] start_addr,
	input wire logic [1:0]  bus_width_sel,
	input wire logic [1:0]  processor_mode,
	input wire logic [3:0]  level_cur
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	wdt_pulse_len_a: assert property ($rose(sys_reset) |-> sys_reset[*4] ##1 !sys_reset)
		else $error("watchdog reset pulse length wrong");
	mode_kept_a: assert property (sys_reset && $past(sys_reset) |-> $stable(processor_mode))
		else $error("processor mode changed during watchdog reset");
	start_addr_a: assert property ($stable(reset_vector) |-> start_addr == {reset_vector[31:2], 2'b00})
		else $error("start address not decoded from vector");
	bus_width_a: assert property ($stable(reset_vector) |-> bus_width_sel == reset_vector[1:0])
		else $error("bus width not taken from vector");
	settle_gate_a: assert property (!$past(det_valid) |-> !$rose(supply_crossing_flag))
		else $error("crossing flagged before settle");
	fall_flag_a: assert property (det_valid && $past(det_valid) && $past(det_valid, 2)
		&& $fell(supply_level_flag)
		|-> supply_crossing_flag)
		else $error("falling crossing not flagged");
	rise_flag_a: assert property (det_valid && $past(det_valid) && $past(det_valid, 2)
		&& $rose(supply_level_flag)
		|-> supply_crossing_flag)
		else $error("rising crossing not flagged");
	cross_irq_a: assert property ($rose(supply_crossing_flag) && supply_irq_enable
		|-> ##[0:1] shared_irq)
		else $error("no request on crossing");
	sticky_hold_a: assert property (supply_crossing_flag && !crossing_clr && !sys_reset
		|=> supply_crossing_flag)
		else $error("crossing flag dropped without clear");
	level_lock_a: assert property (level_wr && (!monitor_write_unlock || detector_enable)
		&& !sys_reset |=> $stable(level_cur))
		else $error("locked level write taken");
	level_take_a: assert property (level_wr && monitor_write_unlock && !detector_enable
		&& !sys_reset |=> level_cur == $past(detect_level_select))
		else $error("unlocked level write lost");
endmodule

// file: wdt_reset_and_low_voltage_monitor_bench.sv
// testbench: both ends joined, software port driven, read data checked
`timescale 1ns/1ps
module wdt_reset_and_low_voltage_monitor_bench;
	import wrm_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic        i_ref_clk = 1'b0;
	logic        i_rst     = 1'b1;
	logic [3:0]  i_addr    = 4'h0;
	logic [31:0] i_wdata   = 32'h0;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic        below     = 1'b0;
	logic        above     = 1'b1;
	logic        wdt_uf    = 1'b0;
	logic        wdt_irq   = 1'b0;
	logic        osc_irq   = 1'b0;
	logic        rd_q      = 1'b0;
	logic        irq_q     = 1'b0;
	logic [31:0] o_rdata;
	logic        o_irq;
	logic [31:0] seed      = 32'h1e30a22f;
	logic [31:0] v;
	logic [3:0]  lv;
	logic [31:0] exp_q[$];
	int          miscompares = 0;
	int          check_count = 0;
	int          irq_rises   = 0;

	always #5 i_ref_clk = ~i_ref_clk;
	wrm_if link ();
	wrm_device #(.SETTLE_CYC(3)) i_wrm_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_cmp_below_fall(below), .i_cmp_above_rise(above), .i_wdt_underflow(wdt_uf),
		.i_wdt_irq(wdt_irq), .i_osc_stop_irq(osc_irq), .bus(link));
	wrm_ctrl i_wrm_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .bus(link));
	wrm_props i_wrm_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.detector_enable(link.detector_enable), .monitor_write_unlock(link.monitor_write_unlock),
		.supply_irq_enable(link.supply_irq_enable), .detect_level_select(link.detect_level_select),
		.level_wr(link.level_wr), .crossing_clr(link.crossing_clr), .reset_vector(link.reset_vector),
		.supply_level_flag(link.supply_level_flag), .supply_crossing_flag(link.supply_crossing_flag),
		.det_valid(link.det_valid), .shared_irq(link.shared_irq), .sys_reset(link.sys_reset),
		.start_addr(link.start_addr), .bus_width_sel(link.bus_width_sel),
		.processor_mode(link.processor_mode), .level_cur(link.level_cur));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// one call per edge, so no strobe is assigned twice in a time step
	task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		cyc(1'b1, 1'b0, a, d);
		cyc(1'b0, 1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		cyc(1'b0, 1'b1, a, 32'h0);
		cyc(1'b0, 1'b0, a, 32'h0);
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 4'h0, 32'h0);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge i_ref_clk) begin
		if (rd_q)
			chk(o_rdata, exp_q.pop_front());
		rd_q <= i_rd;
		irq_q <= o_irq;
		if (o_irq === 1'b1 && irq_q === 1'b0)
			irq_rises++;
	end
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		miscompares++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rd(ADR_STATUS, 32'h1);
		rd(ADR_CTRL, 32'h0);
		rd(4'hf, 32'h0);
		wr(ADR_LEVEL, 32'h9);
		rd(ADR_LEVEL, 32'h0);
		seed = xs(seed);
		lv = seed[3:0];
		wr(ADR_CTRL, 32'h4);
		wr(ADR_LEVEL, {28'h0, lv});
		rd(ADR_LEVEL, {28'h0, lv});
		wr(ADR_CTRL, 32'h5);
		rd(ADR_STATUS, 32'h1);
		wr(ADR_LEVEL, {28'h0, ~lv});
		rd(ADR_LEVEL, {28'h0, lv});
		wr(ADR_MODE, 32'h1);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			v = {seed[31:2], i[1:0]};
			wr(ADR_VECTOR, v);
			rd(ADR_VECTOR, {v[31:2], 2'b00});
			rd(ADR_MODE, {28'h0, v[1:0], 2'b01});
		end
		wr(ADR_CTRL, 32'h3);
		idle(8);
		rd(ADR_STATUS, 32'h5);
		below <= 1'b1;
		above <= 1'b0;
		idle(6);
		rd(ADR_STATUS, 32'h6);
		idle(4);
		rd(ADR_STATUS, 32'h6);
		wr(ADR_STATUS, 32'h0);
		rd(ADR_STATUS, 32'h4);
		below <= 1'b0;
		above <= 1'b1;
		idle(6);
		rd(ADR_STATUS, 32'h7);
		wdt_irq <= 1'b1;
		idle(1);
		wdt_irq <= 1'b0;
		idle(3);
		osc_irq <= 1'b1;
		idle(1);
		osc_irq <= 1'b0;
		idle(4);
		chk(32'(irq_rises), 32'h4);
		wdt_uf <= 1'b1;
		idle(1);
		wdt_uf <= 1'b0;
		idle(8);
		rd(ADR_STATUS, 32'h7);
		wr(ADR_CTRL, 32'hb);
		wdt_uf <= 1'b1;
		idle(1);
		wdt_uf <= 1'b0;
		idle(8);
		rd(ADR_MODE, {28'h0, v[1:0], 2'b01});
		rd(ADR_VECTOR, {v[31:2], 2'b00});
		rd(ADR_LEVEL, {28'h0, LEVEL_RST});
		rd(ADR_CTRL, 32'h0);
		rd(ADR_STATUS, 32'h1);
		wr(ADR_CTRL, 32'h1);
		idle(8);
		below <= 1'b1;
		above <= 1'b0;
		idle(6);
		rd(ADR_STATUS, 32'h6);
		chk(32'(irq_rises), 32'h4);
		wr(ADR_CTRL, 32'h3);
		below <= 1'b0;
		above <= 1'b1;
		idle(6);
		rd(ADR_STATUS, 32'h7);
		chk(32'(irq_rises), 32'h4);
		idle(2);
		tally_and_finish();
	end
endmodule
